// >>> cpts_steer.sv
// Phase offset steering, combo frequency steering and time-of-day accumulator.
// Assumes all inputs except i_link_quality are synchronous to i_clock, which
// here also stands for the output-divider clock that drives the accumulator.
// Functional notes
// - Per-input phase offset register for each reference.
// - Channel phase offset independent of active input.
// - Applied offset is input plus channel offsets.
// - Recompute applied offset on every switchover.
// - Offset adds to phase error into filter.
// - Combo accepts steering from up to two channels.
// - Combo frequency joins the steering word, not the loop filter word.
// - Suppress physical reference on low quality level.
// - Pulse-per-second shift up to half second.
// - Non-system channel is source or satellite.
// - Satellite applies source frequency steering.
// - Satellite steered by source-satellite phase difference.
// - Accept initial difference up to half period.
// - Time accumulator tracks second channel clock.
// - Seconds 48, nanoseconds 32 wrapping, sub-ns 8.
// - Runs on divider clock, M/N 500MHz rates.
// - Also supports M/N 625MHz Ethernet rates.
// - Other rates: plain 80-bit cycle counter; here ns counts cycles and still wraps into seconds at 999999999.
// - Flexible modulus avoids sub-ns truncation.
//
// Register access over Avalon-MM and the address map were left to the implementer.
module cpts_steer
    import cpts_pkg::*;
#(
    parameter int PW = 32  // Width of phase and frequency words.
) (
    input  wire logic          i_clock,
    input  wire logic          i_rst_b,
    input  wire logic [7:0]    i_address,
    input  wire logic          i_read,
    input  wire logic          i_write,
    input  wire logic [31:0]   i_writedata,
    input  wire logic [3:0]    i_byteenable,
    output logic               o_waitrequest,
    output logic [31:0]        o_readdata,
    input  wire logic [1:0]    i_active_input,
    input  wire logic [PW-1:0] i_phase_error,
    input  wire logic          i_phase_valid,
    input  wire logic [PW-1:0] i_source_freq,
    input  wire logic [PW-1:0] i_sat_phase_diff,
    input  wire logic [3:0]    i_link_quality,
    output logic [PW-1:0]      o_filter_in,
    output logic               o_filter_valid,
    output logic [PW-1:0]      o_freq_steer,
    output logic               o_ref_suppress,
    output logic [31:0]        o_pps_shift,
    output logic [47:0]        o_tod_sec,
    output logic [31:0]        o_tod_ns,
    output logic [7:0]         o_tod_subns
);

    // Software-visible storage.
    logic [PW-1:0] in_ofs_reg [4];  // Per-input phase offsets.
    logic [PW-1:0] in_ofs_next [4];  // Next per-input phase offsets.
    logic [PW-1:0] chan_ofs_reg;  // Channel phase offset.
    logic [PW-1:0] chan_ofs_next;  // Next channel phase offset.
    logic [31:0]   ctl_reg;  // Control bits.
    logic [31:0]   ctl_next;  // Next control bits.
    logic [31:0]   inc_ns_reg;  // Whole nanoseconds per divider cycle.
    logic [31:0]   inc_ns_next;  // Next whole increment.
    logic [15:0]   inc_frac_reg;  // Fraction numerator per cycle.
    logic [15:0]   inc_frac_next;  // Next fraction numerator.
    logic [15:0]   inc_mod_reg;  // Fraction modulus.
    logic [15:0]   inc_mod_next;  // Next fraction modulus.
    logic [PW-1:0] steer_a_reg;  // First combo steering word.
    logic [PW-1:0] steer_a_next;  // Next first combo word.
    logic [PW-1:0] steer_b_reg;  // Second combo steering word.
    logic [PW-1:0] steer_b_next;  // Next second combo word.
    logic [31:0]   pps_reg;  // Signed pulse-per-second shift in ns.
    logic [31:0]   pps_next;  // Next shift.
    cpts_bus_t     bus_reg;  // Slave phase.
    cpts_bus_t     bus_next;  // Next slave phase.
    logic          wait_reg;  // Registered waitrequest, low only in the answer cycle.
    logic          wait_next;  // Next waitrequest.
    logic [31:0]   rd_reg;  // Read data.
    logic [31:0]   rd_next;  // Next read data.
    logic [31:0]   wmask;  // Byte-enable mask.

    // Two-flop synchroniser for the external quality level.
    logic [3:0] ql_meta_reg;  // First stage, read only by the second.
    logic [3:0] ql_sync_reg;  // Usable quality level.

    // Synchronises the quality level from the physical-layer recovery.
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            ql_meta_reg <= 4'h0;
            ql_sync_reg <= 4'h0;
        end else begin
            ql_meta_reg <= i_link_quality;
            ql_sync_reg <= ql_meta_reg;
        end
    end

    // Expands byte enables into a write mask.
    always_comb begin
        for (int b = 0; b < 4; b++) begin
            wmask[b*8 +: 8] = {8{i_byteenable[b]}};
        end
    end

    // Bus slave: every access completes one cycle after it is presented.
    always_comb begin
        for (int k = 0; k < 4; k++) begin
            in_ofs_next[k] = in_ofs_reg[k];
        end
        chan_ofs_next = chan_ofs_reg;
        ctl_next      = ctl_reg;
        inc_ns_next   = inc_ns_reg;
        inc_frac_next = inc_frac_reg;
        inc_mod_next  = inc_mod_reg;
        steer_a_next  = steer_a_reg;
        steer_b_next  = steer_b_reg;
        pps_next      = pps_reg;
        rd_next       = rd_reg;
        bus_next      = CPTS_BUS_IDLE;
        unique case (bus_reg)
            CPTS_BUS_IDLE: begin
                // A request is answered on the following edge.
                if (i_read || i_write) begin
                    bus_next = CPTS_BUS_DONE;
                end
            end
            CPTS_BUS_DONE: begin
                // Answer phase: waitrequest is low for this one cycle.
                bus_next = CPTS_BUS_IDLE;
            end
            default: bus_next = CPTS_BUS_IDLE;
        endcase
        // A write lands at the answer edge, while the master still holds it.
        if (i_write && (bus_reg == CPTS_BUS_DONE)) begin
                    unique case (i_address)
                        `CPTS_OFF_INPUT_OFS0: in_ofs_next[0] = PW'((in_ofs_reg[0] & ~wmask) | (i_writedata & wmask));
                        `CPTS_OFF_INPUT_OFS1: in_ofs_next[1] = PW'((in_ofs_reg[1] & ~wmask) | (i_writedata & wmask));
                        `CPTS_OFF_INPUT_OFS2: in_ofs_next[2] = PW'((in_ofs_reg[2] & ~wmask) | (i_writedata & wmask));
                        `CPTS_OFF_INPUT_OFS3: in_ofs_next[3] = PW'((in_ofs_reg[3] & ~wmask) | (i_writedata & wmask));
                        `CPTS_OFF_CHAN_OFS:   chan_ofs_next = PW'((chan_ofs_reg & ~wmask) | (i_writedata & wmask));
                        `CPTS_OFF_CONTROL:    ctl_next = (ctl_reg & ~wmask) | (i_writedata & wmask);
                        `CPTS_OFF_INC_NS:     inc_ns_next = (inc_ns_reg & ~wmask) | (i_writedata & wmask);
                        `CPTS_OFF_INC_FRAC:   inc_frac_next = i_writedata[15:0];
                        `CPTS_OFF_INC_MOD:    inc_mod_next = i_writedata[15:0];
                        `CPTS_OFF_STEER_A:    steer_a_next = PW'(i_writedata);
                        `CPTS_OFF_STEER_B:    steer_b_next = PW'(i_writedata);
                        `CPTS_OFF_PPS_SHIFT:  pps_next = (pps_reg & ~wmask) | (i_writedata & wmask);
                        default: begin
                            // Writes to other addresses are dropped.
                        end
                    endcase
                end
                // Read data is fetched at the taking edge, so it stands in the answer cycle.
                if (i_read && (bus_reg == CPTS_BUS_IDLE)) begin
                    unique case (i_address)
                        `CPTS_OFF_INPUT_OFS0:   rd_next = 32'(in_ofs_reg[0]);
                        `CPTS_OFF_INPUT_OFS1:   rd_next = 32'(in_ofs_reg[1]);
                        `CPTS_OFF_INPUT_OFS2:   rd_next = 32'(in_ofs_reg[2]);
                        `CPTS_OFF_INPUT_OFS3:   rd_next = 32'(in_ofs_reg[3]);
                        `CPTS_OFF_CHAN_OFS:     rd_next = 32'(chan_ofs_reg);
                        `CPTS_OFF_CONTROL:      rd_next = ctl_reg;
                        `CPTS_OFF_INC_NS:       rd_next = inc_ns_reg;
                        `CPTS_OFF_INC_FRAC:     rd_next = {16'h0000, inc_frac_reg};
                        `CPTS_OFF_INC_MOD:      rd_next = {16'h0000, inc_mod_reg};
                        `CPTS_OFF_STEER_A:      rd_next = 32'(steer_a_reg);
                        `CPTS_OFF_STEER_B:      rd_next = 32'(steer_b_reg);
                        `CPTS_OFF_PPS_SHIFT:    rd_next = pps_reg;
                        `CPTS_OFF_TIME_NS:      rd_next = o_tod_ns;
                        `CPTS_OFF_TIME_SEC_LO:  rd_next = o_tod_sec[31:0];
                        `CPTS_OFF_TIME_SEC_HI:  rd_next = {16'h0000, o_tod_sec[47:32]};
                        `CPTS_OFF_STATUS:       rd_next = {23'h000000, o_ref_suppress, o_tod_subns};
                        default:                rd_next = `CPTS_UNMAPPED_DATA;
                    endcase
                end
        // Waitrequest comes from a flop so that the output is glitch free.
        wait_next = (bus_next != CPTS_BUS_DONE);
        // Clamp the pulse-per-second shift to half a second either way.
        if ($signed(pps_next) > $signed(`CPTS_PPS_HALF_NS)) begin
            pps_next = `CPTS_PPS_HALF_NS;
        end else if ($signed(pps_next) < -$signed(`CPTS_PPS_HALF_NS)) begin
            pps_next = -`CPTS_PPS_HALF_NS;
        end
    end

    // Registers the bus slave state and software registers.
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            for (int k = 0; k < 4; k++) begin
                in_ofs_reg[k] <= '0;
            end
            chan_ofs_reg <= '0;
            ctl_reg      <= {20'h00000, `CPTS_QL_MIN_RST, 8'h00};
            inc_ns_reg   <= `CPTS_INC_NS_RST;
            inc_frac_reg <= 16'h0000;
            inc_mod_reg  <= 16'h0001;
            steer_a_reg  <= '0;
            steer_b_reg  <= '0;
            pps_reg      <= 32'h0000_0000;
            bus_reg      <= CPTS_BUS_IDLE;
            wait_reg     <= 1'b1;
            rd_reg       <= 32'h0000_0000;
        end else begin
            for (int k = 0; k < 4; k++) begin
                in_ofs_reg[k] <= in_ofs_next[k];
            end
            chan_ofs_reg <= chan_ofs_next;
            ctl_reg      <= ctl_next;
            inc_ns_reg   <= inc_ns_next;
            inc_frac_reg <= inc_frac_next;
            inc_mod_reg  <= inc_mod_next;
            steer_a_reg  <= steer_a_next;
            steer_b_reg  <= steer_b_next;
            pps_reg      <= pps_next;
            bus_reg      <= bus_next;
            wait_reg     <= wait_next;
            rd_reg       <= rd_next;
        end
    end

    assign o_readdata    = rd_reg;
    assign o_waitrequest = wait_reg;
    assign o_pps_shift   = pps_reg;

    // Steering datapath state.
    logic [PW-1:0] filt_reg;  // Word to the loop filter.
    logic [PW-1:0] filt_next;  // Next loop filter word.
    logic          fval_reg;  // Loop filter word valid.
    logic          fval_next;  // Next valid.
    logic [PW-1:0] freq_reg;  // Frequency steering word.
    logic [PW-1:0] freq_next;  // Next frequency steering word.
    logic          sup_reg;  // Physical reference suppressed.
    logic          sup_next;  // Next suppress flag.
    logic [PW-1:0] applied;  // Applied phase offset, input plus channel.

    // Forms the filter input and the frequency steering word.
    always_comb begin
        // Selected from the live active input, so any switchover is followed at once.
        applied   = in_ofs_reg[i_active_input] + chan_ofs_reg;
        fval_next = i_phase_valid;
        filt_next = filt_reg;
        if (ctl_reg[`CPTS_CTL_SAT]) begin
            // A satellite drives the filter from the source-to-satellite phase.
            if (i_phase_valid) begin
                filt_next = i_sat_phase_diff;
            end
            freq_next = i_source_freq;
        end else begin
            if (i_phase_valid) begin
                filt_next = i_phase_error + applied;
            end
            freq_next = '0;
        end
        // Combo contributions join only here, behind the loop filter word.
        if (ctl_reg[`CPTS_CTL_COMBO_A]) begin
            freq_next = freq_next + steer_a_reg;
        end
        if (ctl_reg[`CPTS_CTL_COMBO_B]) begin
            freq_next = freq_next + steer_b_reg;
        end
        sup_next = ctl_reg[`CPTS_CTL_SUPPRESS]
                   && (ql_sync_reg < ctl_reg[`CPTS_CTL_QL_HI:`CPTS_CTL_QL_LO]);
    end

    // Registers the steering outputs.
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            filt_reg <= '0;
            fval_reg <= 1'b0;
            freq_reg <= '0;
            sup_reg  <= 1'b0;
        end else begin
            filt_reg <= filt_next;
            fval_reg <= fval_next;
            freq_reg <= freq_next;
            sup_reg  <= sup_next;
        end
    end

    assign o_filter_in    = filt_reg;
    assign o_filter_valid = fval_reg;
    assign o_freq_steer   = freq_reg;
    assign o_ref_suppress = sup_reg;

    // Time-of-day accumulator state.
    logic [47:0] sec_reg;  // Seconds.
    logic [47:0] sec_next;  // Next seconds.
    logic [31:0] ns_reg;  // Nanoseconds.
    logic [31:0] ns_next;  // Next nanoseconds.
    logic [7:0]  sub_reg;  // Sub-nanoseconds.
    logic [7:0]  sub_next;  // Next sub-nanoseconds.
    logic [15:0] rem_reg;  // Flexible-modulus remainder.
    logic [15:0] rem_next;  // Next remainder.

    // Advances the accumulator once per divider clock.
    always_comb begin
        logic [32:0] ns_sum;
        logic [16:0] rem_sum;
        logic [8:0]  sub_sum;
        ns_sum  = 33'h000000000;
        rem_sum = 17'h00000;
        sub_sum = 9'h000;
        rem_next = rem_reg;
        sub_next = sub_reg;
        if (ctl_reg[`CPTS_CTL_CYCLE]) begin
            // Cycle counter mode: one count per cycle, sub-ns held at zero.
            ns_sum   = {1'b0, ns_reg} + 33'h000000001;
            sub_next = 8'h00;
            rem_next = 16'h0000;
        end else begin
            // Sub-ns step averages frac/mod units per cycle, with the remainder carried over.
            rem_sum = {1'b0, rem_reg} + {1'b0, inc_frac_reg};
            sub_sum = {1'b0, sub_reg};
            // Remainder reaching the modulus yields one sub-ns unit.
            if (rem_sum >= {1'b0, inc_mod_reg}) begin
                rem_sum = rem_sum - {1'b0, inc_mod_reg};
                sub_sum = sub_sum + 9'h001;
            end
            rem_next = rem_sum[15:0];
            sub_next = sub_sum[7:0];
            ns_sum   = {1'b0, ns_reg} + {1'b0, inc_ns_reg} + {32'h0, sub_sum[8]};
        end
        // Wrap carries into seconds in the same cycle, keeping the remainder.
        if (ns_sum > {1'b0, `CPTS_NS_WRAP}) begin
            ns_next  = 32'(ns_sum - {1'b0, `CPTS_NS_WRAP} - 33'h000000001);
            sec_next = sec_reg + 48'h000000000001;
        end else begin
            ns_next  = ns_sum[31:0];
            sec_next = sec_reg;
        end
    end

    // Registers the accumulator.
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            sec_reg <= 48'h000000000000;
            ns_reg  <= 32'h00000000;
            sub_reg <= 8'h00;
            rem_reg <= 16'h0000;
        end else begin
            sec_reg <= sec_next;
            ns_reg  <= ns_next;
            sub_reg <= sub_next;
            rem_reg <= rem_next;
        end
    end

    assign o_tod_sec   = sec_reg;
    assign o_tod_ns    = ns_reg;
    assign o_tod_subns = sub_reg;

    // The nanosecond field never passes its wrap value.
    AST_NS_RANGE: assert property (@(posedge i_clock) disable iff (!i_rst_b)
        ns_reg <= `CPTS_NS_WRAP) else $error("nanoseconds above wrap");
    // A wrap bumps seconds by exactly one.
    AST_SEC_CARRY: assert property (@(posedge i_clock) disable iff (!i_rst_b)
        (ns_reg < $past(ns_reg)) |-> (sec_reg == $past(sec_reg) + 48'h1))
        else $error("seconds missed carry");
    // Cycle counter mode keeps sub-ns at zero.
    AST_CYCLE_SUB: assert property (@(posedge i_clock) disable iff (!i_rst_b)
        ctl_reg[`CPTS_CTL_CYCLE] |=> (sub_reg == 8'h00)) else $error("sub-ns moved");
    // Filter word is phase error plus the active input's and the channel's offsets.
    AST_FILTER_SUM: assert property (@(posedge i_clock) disable iff (!i_rst_b)
        (i_phase_valid && !ctl_reg[`CPTS_CTL_SAT])
        |=> (filt_reg == $past(i_phase_error) + $past(in_ofs_reg[i_active_input])
             + $past(chan_ofs_reg))) else $error("bad filter word");
    // The filter strobe is the phase strobe delayed by one cycle.
    AST_FILTER_STROBE: assert property (@(posedge i_clock) disable iff (!i_rst_b)
        o_filter_valid == $past(i_phase_valid)) else $error("filter strobe misaligned");
    // Satellite frequency follows the source with no combo terms.
    AST_SAT_FREQ: assert property (@(posedge i_clock) disable iff (!i_rst_b)
        (ctl_reg[`CPTS_CTL_SAT] && !ctl_reg[`CPTS_CTL_COMBO_A] && !ctl_reg[`CPTS_CTL_COMBO_B])
        |=> (freq_reg == $past(i_source_freq))) else $error("satellite frequency wrong");
    // Shift stays within half a second.
    AST_PPS_RANGE: assert property (@(posedge i_clock) disable iff (!i_rst_b)
        ($signed(pps_reg) <= $signed(`CPTS_PPS_HALF_NS))
        && ($signed(pps_reg) >= -$signed(`CPTS_PPS_HALF_NS))) else $error("shift out of range");
    // Every request is answered in the same cycle or the next one.
    AST_BUS_ANSWER: assert property (@(posedge i_clock) disable iff (!i_rst_b)
        (i_read || i_write) |-> ##[0:1] !o_waitrequest) else $error("no bus answer");

endmodule : cpts_steer

// >>> cpts_defines.svh
// Constant definitions for the channel phase and time steering block.
// Assumes inclusion by the package by bare name, compiled ahead of the design file.
`ifndef CPTS_DEFINES_SVH
`define CPTS_DEFINES_SVH
// Register byte offsets on the Avalon-MM slave.
`define CPTS_OFF_INPUT_OFS0   8'h00
`define CPTS_OFF_INPUT_OFS1   8'h04
`define CPTS_OFF_INPUT_OFS2   8'h08
`define CPTS_OFF_INPUT_OFS3   8'h0c
`define CPTS_OFF_CHAN_OFS     8'h10
`define CPTS_OFF_CONTROL      8'h14
`define CPTS_OFF_INC_NS       8'h18
`define CPTS_OFF_INC_FRAC     8'h1c
`define CPTS_OFF_INC_MOD      8'h20
`define CPTS_OFF_STEER_A      8'h24
`define CPTS_OFF_STEER_B      8'h28
`define CPTS_OFF_PPS_SHIFT    8'h2c
`define CPTS_OFF_TIME_NS      8'h30
`define CPTS_OFF_TIME_SEC_LO  8'h34
`define CPTS_OFF_TIME_SEC_HI  8'h38
`define CPTS_OFF_STATUS       8'h3c
// Control register field positions.
`define CPTS_CTL_ACT_LO       0
`define CPTS_CTL_ACT_HI       1
`define CPTS_CTL_SAT          2
`define CPTS_CTL_COMBO_A      3
`define CPTS_CTL_COMBO_B      4
`define CPTS_CTL_CYCLE        5
`define CPTS_CTL_SUPPRESS     6
`define CPTS_CTL_QL_LO        8
`define CPTS_CTL_QL_HI        11
// Reset values and limits.
`define CPTS_NS_WRAP          32'd999999999
`define CPTS_NS_MAX_STEP      32'd2
`define CPTS_INC_NS_RST       32'd1
`define CPTS_QL_MIN_RST       4'h4
`define CPTS_PPS_HALF_NS      32'd500000000
`define CPTS_UNMAPPED_DATA    32'hdeadbeef
`endif

// >>> cpts_pkg.sv
// Types shared by the channel phase and time steering block.
// Assumes cpts_defines.svh sits in the same folder.
package cpts_pkg;
    `include "cpts_defines.svh"
    // Bus slave phases.
    typedef enum logic [1:0] {
        CPTS_BUS_IDLE = 2'b00,
        CPTS_BUS_DONE = 2'b01
    } cpts_bus_t;
endpackage : cpts_pkg

// >>> cpts_ref_model.sv
// Model of the reference side: active input selection and phase samples.
// Assumes the block's clock and its active-low asynchronous reset.
module cpts_ref_model #(
    parameter int PW = 32  // Width of phase words.
) (
    input  wire logic          i_clock,
    input  wire logic          i_rst_b,
    input  wire logic          i_go,
    input  wire logic [1:0]    i_sel,
    input  wire logic [PW-1:0] i_err,
    output logic [1:0]         o_active_input,
    output logic [PW-1:0]      o_phase_error,
    output logic               o_phase_valid
);
    logic          arm_reg;  // A sample is due next cycle.
    logic [PW-1:0] err_reg;  // Error word of the pending sample.
    // The reference switches first and the sample follows one cycle later.
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            {arm_reg, err_reg, o_active_input, o_phase_error, o_phase_valid} <= '0;
        end else begin
            arm_reg       <= i_go;
            o_phase_valid <= arm_reg;
            // Outside a strobe the word toggles, so stale data never looks valid.
            o_phase_error <= arm_reg ? err_reg : ~o_phase_error;
            if (i_go) begin
                o_active_input <= i_sel;
                err_reg        <= i_err;
            end
        end
    end
endmodule : cpts_ref_model

// >>> testbench.sv
// Self-checking bench for the steering block and its reference model.
// Assumes one 125 MHz clock that also stands for the divider clock.
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin n_mismatch++; \
    $display("mismatch %s expected %h seen %h", n, e, g); end end
module testbench;
    import cpts_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic        i_clock = 0, i_rst_b = 0, i_read = 0, i_write = 0, go = 0, pv_d = 0;
    logic [7:0]  i_address = 0;
    logic [31:0] i_writedata = 0, err = 0, src = 0, sdif = 0, e, t0, ofs [4], rq [$], fq [$];
    logic [3:0]  i_link_quality = 4'hf;
    logic [1:0]  sel = 0, act;
    logic        wr, fv, waitr, supp;
    logic [31:0] rdat, perr, fin, fst, pps, ns;
    logic [47:0] sec, s0;
    logic [7:0]  subns;
    int          n_mismatch = 0, checked = 0, i;
    // Free-running clock of 8 ns period.
    always #4 i_clock = ~i_clock;
    cpts_ref_model cpts_ref_model_inst (.i_clock(i_clock), .i_rst_b(i_rst_b), .i_go(go),
        .i_sel(sel), .i_err(err), .o_active_input(act), .o_phase_error(perr),
        .o_phase_valid(wr));
    cpts_steer cpts_steer_inst (.i_clock(i_clock), .i_rst_b(i_rst_b), .i_address(i_address),
        .i_read(i_read), .i_write(i_write), .i_writedata(i_writedata), .i_byteenable(4'hf),
        .o_waitrequest(waitr), .o_readdata(rdat), .i_active_input(act), .i_phase_error(perr),
        .i_phase_valid(wr), .i_source_freq(src), .i_sat_phase_diff(sdif),
        .i_link_quality(i_link_quality), .o_filter_in(fin), .o_filter_valid(fv),
        .o_freq_steer(fst), .o_ref_suppress(supp), .o_pps_shift(pps), .o_tod_sec(sec),
        .o_tod_ns(ns), .o_tod_subns(subns));
    // Prints the counts and the verdict, then ends the run.
    task automatic report_and_stop();
        $display("checked %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : report_and_stop
    // One Avalon-MM transfer, held until waitrequest is seen low.
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge i_clock);
        {i_write, i_read, i_address, i_writedata} <= {w, !w, a, d};
        do begin
            @(posedge i_clock);
            n++;
        end while (waitr !== 1'b0 && n < 20);
        if (n >= 20) begin
            n_mismatch++;
            report_and_stop();
        end
        {i_write, i_read} <= 2'b00;
    endtask : bus
    // Read with the expected word noted for the monitor.
    task automatic rd(input logic [7:0] a, input logic [31:0] x);
        rq.push_back(x);
        bus(1'b0, a, 32'h0);
    endtask : rd
    // Asks the reference model for one sample on input s with error v.
    task automatic send(input logic [1:0] s, input logic [31:0] v);
        @(posedge i_clock);
        {sel, err, go} <= {s, v, 1'b1};
        @(posedge i_clock);
        go <= 1'b0;
        repeat (2) @(posedge i_clock);
    endtask : send
    // Sample strobe delayed by one cycle, the expected filter strobe.
    always @(posedge i_clock) pv_d <= wr;
    // Monitor: each answer is compared with the oldest note.
    always @(posedge i_clock) begin
        if (i_read && waitr === 1'b0) `CHK("readdata", rq.size() ? rq.pop_front() : 'x, rdat)
    end
    always @(negedge i_clock) begin
        `CHK("filter_valid", pv_d, fv)
        if (fv === 1'b1) `CHK("filter_in", fq.size() ? fq.pop_front() : 'x, fin)
    end
    // Main sequence.
    initial begin
        void'($urandom(91));
        repeat (10) @(posedge i_clock);
        i_rst_b <= 1'b1;
        rd(`CPTS_OFF_CONTROL, 32'h400);
        rd(`CPTS_OFF_INC_NS, `CPTS_INC_NS_RST);
        rd(8'h40, `CPTS_UNMAPPED_DATA);
        $display("test reset values done");
        src <= $urandom;
        t0 = $urandom;
        bus(1'b1, `CPTS_OFF_CHAN_OFS, t0);
        for (i = 0; i < 4; i++) begin
            ofs[i] = $urandom;
            bus(1'b1, 8'(i * 4), ofs[i]);
            rd(8'(i * 4), ofs[i]);
        end
        rd(`CPTS_OFF_CHAN_OFS, t0);
        // Switch inputs between back-to-back samples.
        for (i = 0; i < 12; i++) begin
            e = $urandom;
            fq.push_back(e + ofs[i % 4] + t0);
            send(2'(i % 4), e);
        end
        $display("test phase offsets done");
        // Satellite, then satellite with both combo terms.
        e = $urandom;
        bus(1'b1, `CPTS_OFF_STEER_A, e);
        bus(1'b1, `CPTS_OFF_STEER_B, ofs[0]);
        for (i = 0; i < 2; i++) begin
            bus(1'b1, `CPTS_OFF_CONTROL, i ? 32'h41c : 32'h404);
            t0 = $urandom;
            sdif <= t0;
            fq.push_back(t0);
            send(2'd1, e);
            `CHK("freq_steer", i ? src + e + ofs[0] : src, fst)
        end
        $display("test satellite done");
        for (i = 0; i < 3; i++) begin
            e = i == 0 ? 32'd600000000 : i == 1 ? -32'sd600000000 : 32'd123;
            bus(1'b1, `CPTS_OFF_PPS_SHIFT, e);
            repeat (2) @(posedge i_clock);
            e = i == 0 ? `CPTS_PPS_HALF_NS : i == 1 ? -`CPTS_PPS_HALF_NS : 32'd123;
            `CHK("pps_shift", e, pps)
        end
        $display("test pps shift done");
        bus(1'b1, `CPTS_OFF_CONTROL, 32'h440);
        for (i = 3; i < 5; i++) begin
            i_link_quality <= 4'(i);
            repeat (6) @(posedge i_clock);
            `CHK("ref_suppress", 1'(i < 4), supp)
        end
        $display("test suppress done");
        bus(1'b1, `CPTS_OFF_INC_NS, 32'd7);
        bus(1'b1, `CPTS_OFF_INC_FRAC, 32'd1);
        bus(1'b1, `CPTS_OFF_INC_MOD, 32'd3);
        repeat (2) @(negedge i_clock);
        t0 = subns;
        repeat (9) @(negedge i_clock);
        `CHK("subns_step", 8'd3, 8'(subns - t0[7:0]))
        for (i = 0; i < 2; i++) begin
            repeat (3) @(negedge i_clock);
            t0 = ns;
            @(negedge i_clock);
            `CHK("ns_step", i ? 32'd1 : 32'd7, ns - t0)
            bus(1'b1, `CPTS_OFF_CONTROL, 32'h20);
        end
        `CHK("subns", 8'h0, subns)
        bus(1'b1, `CPTS_OFF_CONTROL, 32'h0);
        bus(1'b1, `CPTS_OFF_INC_NS, 32'd400000000);
        s0 = sec;
        for (i = 0; i < 50 && sec === s0; i++) begin
            t0 = ns;
            @(negedge i_clock);
        end
        `CHK("sec_carry", s0 + 48'h1, sec)
        `CHK("ns_wrap", t0 + 32'd400000000 - `CPTS_NS_WRAP - 32'd1, ns)
        $display("test time accumulator done");
        report_and_stop();
    end
endmodule : testbench
